// file: design/fpr_regs.vh
// Purpose: Register map and timing constants of the fan drive ramp block
// Assumes: AXI4-Lite byte address is four times the register index
// Notes:   Duty 8'hFF is 100 percent; 255 steps make a full ramp
//
// Summary of operation
// - Lock set: writes to the three range/frequency registers are ignored.
// - Lock set: the remote-1 ramp control register ignores writes.
// - Remote-1 governed drives slew toward new duty at the coded rate.
// - Normal table: codes give steps 1,2,3,4,8,12,24,48; 37.5 s down to 0.8 s.
// - Slow table: same steps, full ramp takes 52.2 s down to 1.1 s.
// - One slow bit, shared by drives 1 to 3, makes the chosen ramp four times slower.
// - Smoothing on remote-1 drives only while smoothing enable is one.
// - Lockstep one: speed senses 2, 3 and 4 pair with fan drive 3.
// - Lockstep zero: only speed senses 3 and 4 pair with fan drive 3.
// - Floor-select bits choose off or minimum for drives 1 to 3.
// - Below start minus hysteresis: floor 0 gives zero duty, 1 gives minimum.
// - Ramp control register resets to all zeros.
`ifndef FPR_REGS_VH
`define FPR_REGS_VH

////////////////////////////////////////////////////////////////////////////////
// Register indices (byte address = index * 4)
`define FPR_IDX_CFG6        10'h010
`define FPR_IDX_DUTY1       10'h030
`define FPR_IDX_DUTY2       10'h031
`define FPR_IDX_DUTY3       10'h032
`define FPR_IDX_CFG1        10'h040
`define FPR_IDX_RANGE1      10'h05F
`define FPR_IDX_RANGE2      10'h060
`define FPR_IDX_RANGE3      10'h061
`define FPR_IDX_RCTL1       10'h062

////////////////////////////////////////////////////////////////////////////////
// Reset values
`define FPR_RST_CFG1        8'h00
`define FPR_RST_CFG6        8'h00
`define FPR_RST_RANGE       8'hC4
`define FPR_RST_RCTL1       8'h00

////////////////////////////////////////////////////////////////////////////////
// Field positions
`define FPR_CFG1_LOCK       1
`define FPR_CFG6_SLOW       7
`define FPR_CFG6_X4_R1      0
`define FPR_RCTL_RATE_HI    2
`define FPR_RCTL_RATE_LO    0
`define FPR_RCTL_EN         3
`define FPR_RCTL_SYNC       4
`define FPR_RCTL_FLOOR_LO   5

////////////////////////////////////////////////////////////////////////////////
// Timing
`define FPR_CLK_HZ          25000000
`define FPR_FULL_STEPS      255
`define FPR_RAMP_FAST_DS    375
`define FPR_RAMP_SLOW_DS    522
`define FPR_SLOW_FACTOR     2'h3

////////////////////////////////////////////////////////////////////////////////
// Bus answers
`define FPR_RESP_OKAY       2'h0
`define FPR_RESP_SLVERR     2'h2

`endif

// file: design/fpr_sync3.v
// Purpose: Three-stage synchroniser for pin inputs
// Assumes: Inputs asynchronous to aclk
// Notes:   Output follows only when stages two and three agree
`timescale 1ns/10ps
`default_nettype none
module fpr_sync3 #(
   parameter W = 3
) (
   // Clock and reset
   input  wire         aclk,
   input  wire         aresetn,
   // Pins and filtered levels
   input  wire [W-1:0] pin_in,
   output reg  [W-1:0] level_reg
);
   reg  [W-1:0] s1_reg;
   reg  [W-1:0] s2_reg;
   reg  [W-1:0] s3_reg;
   wire [W-1:0] agree;

   // First stage feeds only the second
   assign agree = ~(s2_reg ^ s3_reg);

   always @(posedge aclk) begin
      if (!aresetn) begin
         s1_reg    <= {W{1'b0}};
         s2_reg    <= {W{1'b0}};
         s3_reg    <= {W{1'b0}};
         level_reg <= {W{1'b0}};
      end else begin
         s1_reg    <= pin_in;
         s2_reg    <= s1_reg;
         s3_reg    <= s2_reg;
         level_reg <= (level_reg & ~agree) | (s3_reg & agree);
      end
   end
endmodule
`default_nettype wire

// file: design/fpr_ramp.v
// Purpose: Slew limiter for one fan drive duty
// Assumes: slot_tick is a one-cycle enable
// Notes:   Never overshoots the target
`timescale 1ns/10ps
`default_nettype none
module fpr_ramp #(
   parameter W = 8
) (
   // Clock and reset
   input  wire         aclk,
   input  wire         aresetn,
   // Control
   input  wire         smooth,
   input  wire         slot_tick,
   input  wire [W-1:0] step,
   input  wire [W-1:0] target,
   // Duty
   output reg  [W-1:0] duty_reg
);
   reg [W-1:0] duty_next;
   reg [W-1:0] diff;

   always @* begin
      duty_next = duty_reg;
      diff      = {W{1'b0}};
      if (!smooth) begin
         duty_next = target;
      end else if (slot_tick) begin
         if (target > duty_reg) begin
            diff      = target - duty_reg;
            duty_next = (diff > step) ? duty_reg + step : target;
         end else begin
            diff      = duty_reg - target;
            duty_next = (diff > step) ? duty_reg - step : target;
         end
      end
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         duty_reg <= {W{1'b0}};
      end else begin
         duty_reg <= duty_next;
      end
   end
endmodule
`default_nettype wire

// file: design/fpr_top.v
// Purpose: Fan drive ramp smoothing, floors and speed-sense pairing
// Assumes: 25 MHz aclk, AXI4-Lite slave, 8-bit registers in lane 0
// Notes:   Unmapped addresses answer SLVERR; locked writes answer OKAY
`timescale 1ns/10ps
`default_nettype none
`include "fpr_regs.vh"
module fpr_top #(
   parameter AW            = 12,
   parameter SLOT_FAST_CYC = `FPR_RAMP_FAST_DS * (`FPR_CLK_HZ / 10) / `FPR_FULL_STEPS,
   parameter SLOT_SLOW_CYC = `FPR_RAMP_SLOW_DS * (`FPR_CLK_HZ / 10) / `FPR_FULL_STEPS
) (
   // Clock and reset
   input  wire          aclk,
   input  wire          aresetn,
   // AXI4-Lite write address
   input  wire [AW-1:0] s_axi_awaddr,
   input  wire          s_axi_awvalid,
   output reg           s_axi_awready,
   // AXI4-Lite write data
   input  wire [31:0]   s_axi_wdata,
   input  wire [3:0]    s_axi_wstrb,
   input  wire          s_axi_wvalid,
   output reg           s_axi_wready,
   // AXI4-Lite write response
   output reg  [1:0]    s_axi_bresp,
   output reg           s_axi_bvalid,
   input  wire          s_axi_bready,
   // AXI4-Lite read address
   input  wire [AW-1:0] s_axi_araddr,
   input  wire          s_axi_arvalid,
   output reg           s_axi_arready,
   // AXI4-Lite read data
   output reg  [31:0]   s_axi_rdata,
   output reg  [1:0]    s_axi_rresp,
   output reg           s_axi_rvalid,
   input  wire          s_axi_rready,
   // Automatic control inputs, bit i for drive i+1
   input  wire [2:0]    auto_mode,
   input  wire [2:0]    remote1_governs,
   input  wire [2:0]    low_temp,
   input  wire [7:0]    drive1_target,
   input  wire [7:0]    drive2_target,
   input  wire [7:0]    drive3_target,
   input  wire [7:0]    drive1_min,
   input  wire [7:0]    drive2_min,
   input  wire [7:0]    drive3_min,
   // Duty outputs
   output wire [7:0]    fan_drive_1,
   output wire [7:0]    fan_drive_2,
   output wire [7:0]    fan_drive_3,
   // Speed sense pins
   input  wire          speed_sense_2,
   input  wire          speed_sense_3,
   input  wire          speed_sense_4,
   // Senses paired with fan drive 3
   output reg  [2:0]    drive3_sense_sel,
   output reg  [2:0]    drive3_sense
);

   ////////////////////////////////////////////////////////////////////////////
   // Helpers

   function [7:0] step_of;
      input [2:0] code;
      begin
         case (code)
            3'h0:    step_of = 8'h01;
            3'h1:    step_of = 8'h02;
            3'h2:    step_of = 8'h03;
            3'h3:    step_of = 8'h04;
            3'h4:    step_of = 8'h08;
            3'h5:    step_of = 8'h0C;
            3'h6:    step_of = 8'h18;
            3'h7:    step_of = 8'h30;
            default: step_of = 8'h01;
         endcase
      end
   endfunction

   function is_mapped;
      input [9:0] idx;
      begin
         case (idx)
            `FPR_IDX_CFG1,
            `FPR_IDX_CFG6,
            `FPR_IDX_DUTY1,
            `FPR_IDX_DUTY2,
            `FPR_IDX_DUTY3,
            `FPR_IDX_RANGE1,
            `FPR_IDX_RANGE2,
            `FPR_IDX_RANGE3,
            `FPR_IDX_RCTL1: is_mapped = 1'b1;
            default:        is_mapped = 1'b0;
         endcase
      end
   endfunction

   function [7:0] floor_of;
      input       auto_on;
      input       low;
      input       floor_min;
      input [7:0] target;
      input [7:0] min_duty;
      begin
         if (auto_on && low) begin
            floor_of = floor_min ? min_duty : 8'h00;
         end else begin
            floor_of = target;
         end
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Registers

   reg  [7:0]    cfg1_reg;
   reg  [7:0]    cfg6_reg;
   reg  [7:0]    range1_reg;
   reg  [7:0]    range2_reg;
   reg  [7:0]    range3_reg;
   reg  [7:0]    rctl1_reg;

   // Write channel state
   reg           aw_full_reg;
   reg           w_full_reg;
   reg  [AW-1:0] awaddr_reg;
   reg  [7:0]    wdata_reg;
   reg           wlane_reg;

   wire [9:0]    widx;
   wire [9:0]    ridx;
   wire          do_write;
   wire          locked;
   wire          wr_en;

   assign widx     = awaddr_reg[11:2];
   assign ridx     = s_axi_araddr[11:2];
   assign do_write = aw_full_reg && w_full_reg && !s_axi_bvalid;
   assign locked   = cfg1_reg[`FPR_CFG1_LOCK];
   assign wr_en    = do_write && wlane_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Write address and data, taken in either order

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         aw_full_reg   <= 1'b0;
         awaddr_reg    <= {AW{1'b0}};
      end else if (s_axi_awvalid && s_axi_awready) begin
         s_axi_awready <= 1'b0;
         aw_full_reg   <= 1'b1;
         awaddr_reg    <= s_axi_awaddr;
      end else if (do_write) begin
         aw_full_reg   <= 1'b0;
      end else if (!aw_full_reg && !s_axi_bvalid) begin
         s_axi_awready <= 1'b1;
      end
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_wready <= 1'b0;
         w_full_reg   <= 1'b0;
         wdata_reg    <= 8'h00;
         wlane_reg    <= 1'b0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         s_axi_wready <= 1'b0;
         w_full_reg   <= 1'b1;
         wdata_reg    <= s_axi_wdata[7:0];
         wlane_reg    <= s_axi_wstrb[0];
      end else if (do_write) begin
         w_full_reg   <= 1'b0;
      end else if (!w_full_reg && !s_axi_bvalid) begin
         s_axi_wready <= 1'b1;
      end
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `FPR_RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= is_mapped(widx) ? `FPR_RESP_OKAY : `FPR_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register writes

   always @(posedge aclk) begin
      if (!aresetn) begin
         cfg1_reg   <= `FPR_RST_CFG1;
         cfg6_reg   <= `FPR_RST_CFG6;
         range1_reg <= `FPR_RST_RANGE;
         range2_reg <= `FPR_RST_RANGE;
         range3_reg <= `FPR_RST_RANGE;
         rctl1_reg  <= `FPR_RST_RCTL1;
      end else if (wr_en) begin
         case (widx)
            `FPR_IDX_CFG1: begin
               // Lock holds until reset
               cfg1_reg <= wdata_reg | (cfg1_reg & (8'h01 << `FPR_CFG1_LOCK));
            end
            `FPR_IDX_CFG6:   cfg6_reg <= wdata_reg;
            `FPR_IDX_RANGE1: if (!locked) range1_reg <= wdata_reg;
            `FPR_IDX_RANGE2: if (!locked) range2_reg <= wdata_reg;
            `FPR_IDX_RANGE3: if (!locked) range3_reg <= wdata_reg;
            `FPR_IDX_RCTL1:  if (!locked) rctl1_reg <= wdata_reg;
            default:         cfg1_reg <= cfg1_reg;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read channel, answer one cycle after the address is taken

   reg [7:0] rd_mux;

   always @* begin
      case (ridx)
         `FPR_IDX_CFG1:   rd_mux = cfg1_reg;
         `FPR_IDX_CFG6:   rd_mux = cfg6_reg;
         `FPR_IDX_DUTY1:  rd_mux = fan_drive_1;
         `FPR_IDX_DUTY2:  rd_mux = fan_drive_2;
         `FPR_IDX_DUTY3:  rd_mux = fan_drive_3;
         `FPR_IDX_RANGE1: rd_mux = range1_reg;
         `FPR_IDX_RANGE2: rd_mux = range2_reg;
         `FPR_IDX_RANGE3: rd_mux = range3_reg;
         `FPR_IDX_RCTL1:  rd_mux = rctl1_reg;
         default:         rd_mux = 8'h00;
      endcase
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= `FPR_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rdata   <= {24'h000000, rd_mux};
         s_axi_rresp   <= is_mapped(ridx) ? `FPR_RESP_OKAY : `FPR_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid  <= 1'b0;
      end else if (!s_axi_rvalid) begin
         s_axi_arready <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Ramp time slot divider

   reg  [23:0] slot_cnt_reg;
   reg  [1:0]  quad_cnt_reg;
   reg         slot_tick_reg;
   wire [23:0] slot_last;
   wire        slot_end;
   wire        x4_slow;

   // Slow table stretches every slot, so codes keep their step sizes
   assign slot_last = cfg6_reg[`FPR_CFG6_SLOW] ?
                      SLOT_SLOW_CYC[23:0] - 24'h000001 :
                      SLOT_FAST_CYC[23:0] - 24'h000001;
   assign slot_end  = (slot_cnt_reg >= slot_last);
   assign x4_slow   = cfg6_reg[`FPR_CFG6_X4_R1];

   always @(posedge aclk) begin
      if (!aresetn) begin
         slot_cnt_reg  <= 24'h000000;
         quad_cnt_reg  <= 2'h0;
         slot_tick_reg <= 1'b0;
      end else if (slot_end) begin
         slot_cnt_reg  <= 24'h000000;
         quad_cnt_reg  <= quad_cnt_reg + 2'h1;
         // Only one slot in four steps when slowed
         slot_tick_reg <= !x4_slow || (quad_cnt_reg == `FPR_SLOW_FACTOR);
      end else begin
         slot_cnt_reg  <= slot_cnt_reg + 24'h000001;
         slot_tick_reg <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Drive duty: floor, then slew or direct

   wire [7:0] step;
   wire       smooth_en;
   wire [2:0] smooth;
   wire [2:0] floor_min;
   wire [7:0] eff1;
   wire [7:0] eff2;
   wire [7:0] eff3;

   assign step      = step_of(rctl1_reg[`FPR_RCTL_RATE_HI:`FPR_RCTL_RATE_LO]);
   assign smooth_en = rctl1_reg[`FPR_RCTL_EN];
   assign smooth    = remote1_governs & {3{smooth_en}};
   assign floor_min = rctl1_reg[`FPR_RCTL_FLOOR_LO+2:`FPR_RCTL_FLOOR_LO];
   assign eff1 = floor_of(auto_mode[0], low_temp[0], floor_min[0], drive1_target, drive1_min);
   assign eff2 = floor_of(auto_mode[1], low_temp[1], floor_min[1], drive2_target, drive2_min);
   assign eff3 = floor_of(auto_mode[2], low_temp[2], floor_min[2], drive3_target, drive3_min);

   fpr_ramp #(.W(8)) u_ramp1 (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .smooth    (smooth[0]),
      .slot_tick (slot_tick_reg),
      .step      (step),
      .target    (eff1),
      .duty_reg  (fan_drive_1)
   );

   fpr_ramp #(.W(8)) u_ramp2 (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .smooth    (smooth[1]),
      .slot_tick (slot_tick_reg),
      .step      (step),
      .target    (eff2),
      .duty_reg  (fan_drive_2)
   );

   fpr_ramp #(.W(8)) u_ramp3 (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .smooth    (smooth[2]),
      .slot_tick (slot_tick_reg),
      .step      (step),
      .target    (eff3),
      .duty_reg  (fan_drive_3)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Speed sense pairing with fan drive 3

   wire [2:0] sense_lvl;

   fpr_sync3 #(.W(3)) u_sync (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .pin_in    ({speed_sense_4, speed_sense_3, speed_sense_2}),
      .level_reg (sense_lvl)
   );

   always @(posedge aclk) begin
      if (!aresetn) begin
         drive3_sense_sel <= 3'h0;
         drive3_sense     <= 3'h0;
      end else begin
         // Bit 0 is sense 2, bit 2 is sense 4
         drive3_sense_sel <= {2'h3, rctl1_reg[`FPR_RCTL_SYNC]};
         drive3_sense     <= sense_lvl & {2'h3, rctl1_reg[`FPR_RCTL_SYNC]};
      end
   end

endmodule
`default_nettype wire

// file: testbench/fpr_monitor.sv
// Purpose: Port checker for the fan drive ramp block
// Assumes: Bound to fpr_top; one clock, sync active-low reset
// Notes:   Sees ports only, so register fields are judged through duty and sense
`timescale 1ns/10ps
`default_nettype none
module fpr_monitor (
   // Clock and reset
   input wire logic       aclk,
   input wire logic       aresetn,
   // Bus handshakes
   input wire logic       s_axi_awvalid,
   input wire logic       s_axi_awready,
   input wire logic       s_axi_wvalid,
   input wire logic       s_axi_wready,
   input wire logic       s_axi_bvalid,
   input wire logic       s_axi_bready,
   input wire logic       s_axi_arvalid,
   input wire logic       s_axi_arready,
   input wire logic       s_axi_rvalid,
   input wire logic       s_axi_rready,
   input wire logic [1:0] s_axi_rresp,
   // Control inputs
   input wire logic [2:0] auto_mode,
   input wire logic [2:0] remote1_governs,
   input wire logic [2:0] low_temp,
   input wire logic [7:0] drive1_target,
   input wire logic [7:0] drive2_min,
   input wire logic [7:0] drive3_target,
   // Outputs watched
   input wire logic [7:0] fan_drive_1,
   input wire logic [7:0] fan_drive_2,
   input wire logic [7:0] fan_drive_3,
   input wire logic [2:0] drive3_sense_sel,
   input wire logic [2:0] drive3_sense
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   ////////////////////////////////////////////////////////////////////////////
   // Bus
   a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
   a_bvalid_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("bvalid held after handshake");
   a_busy_no_ready: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("ready while response pending");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   a_rvalid_drop: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("rvalid held after handshake");

   ////////////////////////////////////////////////////////////////////////////
   // Sense pairing; bit 0 may lag one cycle after lockstep clears
   a_sense_fixed: assert property ($past(aresetn) |-> drive3_sense_sel[2:1] == 2'h3)
      else $error("senses 3 and 4 not paired");
   a_sense_mask: assert property (!drive3_sense_sel[0] && !$past(drive3_sense_sel[0])
      |-> !drive3_sense[0]) else $error("sense 2 passed without lockstep");

   ////////////////////////////////////////////////////////////////////////////
   // Duty
   a_no_overshoot_up: assert property (!auto_mode[0] && fan_drive_1 <= drive1_target
      |=> fan_drive_1 <= $past(drive1_target)) else $error("duty overshoot rising");
   a_no_overshoot_dn: assert property (!auto_mode[0] && fan_drive_1 >= drive1_target
      |=> fan_drive_1 >= $past(drive1_target)) else $error("duty overshoot falling");
   a_floor_drive2: assert property ((!remote1_governs[1] && auto_mode[1] && low_temp[1]) [*2]
      |-> fan_drive_2 == 8'h00 || fan_drive_2 == $past(drive2_min)) else $error("floor duty wrong");
   a_direct_drive3: assert property (!remote1_governs[2] && !auto_mode[2]
      |=> fan_drive_3 == $past(drive3_target)) else $error("ungoverned drive not direct");

   c_unmapped_read: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
   c_lockstep_sense: cover property (drive3_sense_sel[0] && drive3_sense[0]);
   c_ramp_move: cover property (remote1_governs[0] && fan_drive_1 != $past(fan_drive_1));
endmodule
`default_nettype wire

// file: testbench/fpr_top_test.sv
// Purpose: Self-checking bench for the fan drive ramp block
// Assumes: Short slot lengths so every ramp code runs in a few cycles
// Notes:   Lock is tested last since it stays set until reset
`timescale 1ns/10ps
`default_nettype none
`include "fpr_regs.vh"
module fpr_top_test;
   localparam int SLOT  = 8;
   localparam int SLOW  = 12;
   localparam int LIMIT = 20000;
   logic        aclk;
   logic        aresetn;
   logic [11:0] awaddr;
   logic [11:0] araddr;
   logic [31:0] wdata;
   logic [31:0] rdata;
   logic [1:0]  bresp;
   logic [1:0]  rresp;
   logic        awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready;
   logic [2:0]  auto, gov, low, sel, sense;
   logic [7:0]  t1, t2, t3, m1, m2, m3, fan1, fan2, fan3;
   logic        ss2, ss3, ss4;
   int          mismatches;
   int          num_checks;
   int          cycles;
   int          steps [8] = '{1, 2, 3, 4, 8, 12, 24, 48};

   fpr_top #(.SLOT_FAST_CYC(SLOT), .SLOT_SLOW_CYC(SLOW)) fpr_top_i (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .auto_mode(auto), .remote1_governs(gov), .low_temp(low),
      .drive1_target(t1), .drive2_target(t2), .drive3_target(t3),
      .drive1_min(m1), .drive2_min(m2), .drive3_min(m3),
      .fan_drive_1(fan1), .fan_drive_2(fan2), .fan_drive_3(fan3),
      .speed_sense_2(ss2), .speed_sense_3(ss3), .speed_sense_4(ss4),
      .drive3_sense_sel(sel), .drive3_sense(sense));

   initial begin
      aclk = 1'b0;
      forever #20 aclk = ~aclk;
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic end_of_test();
      $display("Checks %0d, mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         mismatches++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask

   // Bus tasks start one edge in so bready/rready are never set twice in a step
   task automatic wr(input logic [9:0] idx, input logic [7:0] d, input logic [1:0] er);
      @(posedge aclk);
      awaddr  <= {idx, 2'h0};
      wdata   <= {24'h000000, d};
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      bready <= 1'b0;
      chk("bresp", er, bresp);
   endtask

   task automatic rd(input logic [9:0] idx, input logic [7:0] ed, input logic [1:0] er);
      @(posedge aclk);
      araddr  <= {idx, 2'h0};
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      rready <= 1'b0;
      chk("rdata", {24'h000000, ed}, rdata);
      chk("rresp", er, rresp);
   endtask

   task automatic wait_chg(output int c);
      logic [7:0] old;
      old = fan1;
      c = 0;
      do begin
         @(posedge aclk);
         c++;
      end while (fan1 === old && c < 400);
   endtask

   // Start from zero duty, then ramp up; interval between steps is the slot
   task automatic ramp(input logic [2:0] code, input int per);
      int c;
      @(posedge aclk) t1 <= 8'h00;
      wr(`FPR_IDX_RCTL1, {5'h00, code}, `FPR_RESP_OKAY);
      repeat (3) @(posedge aclk);
      chk("direct duty", 32'h0, fan1);
      wr(`FPR_IDX_RCTL1, {5'h01, code}, `FPR_RESP_OKAY);
      @(posedge aclk) t1 <= 8'hC8;
      wait_chg(c);
      chk("first step", steps[code], fan1);
      wait_chg(c);
      chk("second step", 2 * steps[code], fan1);
      chk("slot cycles", per, c);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   always @(posedge aclk) begin
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         mismatches++;
         $display("Error cycles expected below %0d seen %0d", LIMIT, cycles);
         end_of_test();
      end
   end

   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready, ss2, ss3, ss4} = '0;
      {awaddr, araddr, wdata, auto, gov, low} = '0;
      {t1, t2, t3, m1, m2, m3} = '0;
      {mismatches, num_checks, cycles} = '0;
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      rd(`FPR_IDX_RCTL1, `FPR_RST_RCTL1, `FPR_RESP_OKAY);
      rd(`FPR_IDX_RANGE1, `FPR_RST_RANGE, `FPR_RESP_OKAY);
      rd(10'h3FF, 8'h00, `FPR_RESP_SLVERR);
      wr(10'h3FF, 8'h55, `FPR_RESP_SLVERR);
      $display("Test reset done");
      // Floors: drive1 and drive3 at minimum, drive2 off
      @(posedge aclk) {auto, low, t1, t2, t3, m1, m2, m3} <= {6'h3F, 24'h505050, 24'h14_1E_28};
      wr(`FPR_IDX_RCTL1, 8'hA0, `FPR_RESP_OKAY);
      repeat (3) @(posedge aclk);
      chk("floor fan1", 32'h14, fan1);
      chk("floor fan2", 32'h00, fan2);
      chk("floor fan3", 32'h28, fan3);
      rd(`FPR_IDX_DUTY1, 8'h14, `FPR_RESP_OKAY);
      wr(`FPR_IDX_RCTL1, 8'h40, `FPR_RESP_OKAY);
      repeat (3) @(posedge aclk);
      chk("floor swap", 32'h00_1E_00, {fan1, fan2, fan3});
      @(posedge aclk) {auto, low} <= 6'h00;
      repeat (3) @(posedge aclk);
      chk("floor off", 32'h50_50_50, {fan1, fan2, fan3});
      $display("Test floors done");
      // Sense pairing with and without lockstep
      @(posedge aclk) {ss2, ss3, ss4} <= 3'h7;
      wr(`FPR_IDX_RCTL1, 8'h00, `FPR_RESP_OKAY);
      repeat (8) @(posedge aclk);
      chk("pair off", 32'h36, {sel, sense});
      wr(`FPR_IDX_RCTL1, 8'h10, `FPR_RESP_OKAY);
      repeat (8) @(posedge aclk);
      chk("pair on", 32'h3F, {sel, sense});
      rd(`FPR_IDX_RCTL1, 8'h10, `FPR_RESP_OKAY);
      $display("Test pairing done");
      // Ramp steps and slot lengths
      @(posedge aclk) gov <= 3'h1;
      for (int k = 0; k < 8; k++) ramp(k[2:0], SLOT);
      wr(`FPR_IDX_CFG6, 8'h80, `FPR_RESP_OKAY);
      ramp(3'h3, SLOW);
      wr(`FPR_IDX_CFG6, 8'h01, `FPR_RESP_OKAY);
      ramp(3'h3, 4 * SLOT);
      rd(`FPR_IDX_CFG6, 8'h01, `FPR_RESP_OKAY);
      wr(`FPR_IDX_CFG6, 8'h00, `FPR_RESP_OKAY);
      $display("Test ramp done");
      // Lock freezes ramp control and range registers
      wr(`FPR_IDX_RANGE1, 8'h35, `FPR_RESP_OKAY);
      rd(`FPR_IDX_RANGE1, 8'h35, `FPR_RESP_OKAY);
      wr(`FPR_IDX_RCTL1, 8'h5B, `FPR_RESP_OKAY);
      wr(`FPR_IDX_CFG1, 8'h02, `FPR_RESP_OKAY);
      wr(`FPR_IDX_RCTL1, 8'h00, `FPR_RESP_OKAY);
      rd(`FPR_IDX_RCTL1, 8'h5B, `FPR_RESP_OKAY);
      for (int k = 0; k < 3; k++) wr(`FPR_IDX_RANGE1 + k, 8'h00, `FPR_RESP_OKAY);
      rd(`FPR_IDX_RANGE1, 8'h35, `FPR_RESP_OKAY);
      rd(`FPR_IDX_RANGE2, `FPR_RST_RANGE, `FPR_RESP_OKAY);
      rd(`FPR_IDX_RANGE3, `FPR_RST_RANGE, `FPR_RESP_OKAY);
      $display("Test lock done");
      end_of_test();
   end
endmodule

bind fpr_top fpr_monitor fpr_monitor_i (
   .aclk(aclk), .aresetn(aresetn),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rresp(s_axi_rresp),
   .auto_mode(auto_mode), .remote1_governs(remote1_governs), .low_temp(low_temp),
   .drive1_target(drive1_target), .drive2_min(drive2_min), .drive3_target(drive3_target),
   .fan_drive_1(fan_drive_1), .fan_drive_2(fan_drive_2), .fan_drive_3(fan_drive_3),
   .drive3_sense_sel(drive3_sense_sel), .drive3_sense(drive3_sense));
`default_nettype wire
